// *** src/rrsa_defs.svh ***
// register offsets, flag positions, reset values for the rotate/subtract alu
`ifndef RRSA_DEFS_SVH
`define RRSA_DEFS_SVH

`define RRSA_OFF_CTRL     8'h00
`define RRSA_OFF_OPERAND  8'h04
`define RRSA_OFF_WREG     8'h08
`define RRSA_OFF_FLAGS    8'h0c
`define RRSA_OFF_RESULT   8'h10

`define RRSA_CTRL_GO_BIT  3

`define RRSA_FLAG_C       0
`define RRSA_FLAG_AC      1
`define RRSA_FLAG_Z       2
`define RRSA_FLAG_OV      3
`define RRSA_FLAG_SC      4
`define RRSA_FLAG_CZ      5

`define RRSA_RST_WREG     8'h00
`define RRSA_RST_FLAGS    6'h00
`define RRSA_RST_BYTE     8'h00

`define RRSA_RESP_OKAY    2'h0
`define RRSA_RESP_SLVERR  2'h2

`endif

// *** src/rrsa_pkg.sv ***
// types shared by the rotate/subtract alu and its users
package rrsa_pkg;

    // operation select; codes 6 and 7 do nothing
    typedef enum logic [2:0] {
        RRSA_ROTATE_RIGHT_MEM           = 3'h0,
        RRSA_ROTATE_RIGHT_TO_WREG       = 3'h1,
        RRSA_ROTATE_RIGHT_CARRY_MEM     = 3'h2,
        RRSA_ROTATE_RIGHT_CARRY_TO_WREG = 3'h3,
        RRSA_SUBTRACT_BORROW_TO_WREG    = 3'h4,
        RRSA_SUBTRACT_BORROW_TO_MEM     = 3'h5,
        RRSA_NOP6                       = 3'h6,
        RRSA_NOP7                       = 3'h7
    } rrsa_op_t;

    // status flags, bit order matches the flags register
    typedef struct packed {
        logic carry_with_zero_flag;
        logic signed_borrow_flag;
        logic sign_error_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } rrsa_flags_t;

    // everything one operation produces
    typedef struct packed {
        logic [7:0]  wreg;
        logic [7:0]  mem_data;
        logic        mem_we;
        rrsa_flags_t flags;
    } rrsa_result_t;

endpackage : rrsa_pkg

// *** src/rrsa_alu.sv ***
// rotate-right and subtract-with-borrow datapath with an axi4-lite slave
//
// How it works
// - rotate memory byte right, bit 0 into bit 7, write back, flags kept.
// - rotated byte goes to working register, memory untouched, flags kept.
// - memory byte and carry rotate as nine-bit ring; only carry changes.
// - rotated byte with old carry in bit 7 to working register; carry=bit0.
// - working register minus memory minus inverted carry into working reg.
// - same difference written to memory; working register keeps its value.
// - carry cleared on negative difference, set on zero or positive.
// - subtracts update six flags: ov, z, half-carry, c, sc, cz only.
`timescale 1ns/100ps
`include "rrsa_defs.svh"

module rrsa_alu
(
    input  wire logic                core_clk,       // 200 mhz core clock
    input  wire logic                nrst,           // async reset, low
    input  wire logic                exec_valid,     // decoder issues op
    input  wire rrsa_pkg::rrsa_op_t  exec_op,        // operation to run
    input  wire logic [7:0]          exec_mem_data,  // addressed byte
    output logic                     mem_wr_en,      // memory write pulse
    output logic [7:0]               mem_wr_data,    // byte to write back
    output logic [7:0]               wreg_out,       // working register
    output rrsa_pkg::rrsa_flags_t    flags_out,      // status flags
    input  wire logic [7:0]          s_axi_awaddr,   // write address
    input  wire logic                s_axi_awvalid,  // write address valid
    output logic                     s_axi_awready,  // write address ready
    input  wire logic [31:0]         s_axi_wdata,    // write data
    input  wire logic [3:0]          s_axi_wstrb,    // write byte enables
    input  wire logic                s_axi_wvalid,   // write data valid
    output logic                     s_axi_wready,   // write data ready
    output logic [1:0]               s_axi_bresp,    // write response
    output logic                     s_axi_bvalid,   // write response valid
    input  wire logic                s_axi_bready,   // write response ready
    input  wire logic [7:0]          s_axi_araddr,   // read address
    input  wire logic                s_axi_arvalid,  // read address valid
    output logic                     s_axi_arready,  // read address ready
    output logic [31:0]              s_axi_rdata,    // read data
    output logic [1:0]               s_axi_rresp,    // read response
    output logic                     s_axi_rvalid,   // read data valid
    input  wire logic                s_axi_rready    // read data ready
);
    import rrsa_pkg::*;

    // one operation: rotates and subtract-with-borrow on 8-bit operands
    function automatic rrsa_result_t alu_exec(input rrsa_op_t    op,
                                              input logic [7:0]  a,
                                              input logic [7:0]  m,
                                              input rrsa_flags_t f);
        rrsa_result_t r;
        logic [8:0]   diff;
        logic [4:0]   low;
        logic [7:0]   res;
        logic         nb;
        r    = '{wreg: a, mem_data: m, mem_we: 1'b0, flags: f};
        nb   = ~f.carry_flag;
        diff = {1'b0, a} - {1'b0, m} - {8'h00, nb};
        low  = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, nb};
        res  = diff[7:0];
        case (op)
            RRSA_ROTATE_RIGHT_MEM:
            begin
                r.mem_data = {m[0], m[7:1]};
                r.mem_we   = 1'b1;
            end
            RRSA_ROTATE_RIGHT_TO_WREG:
            begin
                r.wreg = {m[0], m[7:1]};
            end
            RRSA_ROTATE_RIGHT_CARRY_MEM:
            begin
                r.mem_data     = {f.carry_flag, m[7:1]};
                r.mem_we       = 1'b1;
                r.flags.carry_flag = m[0];
            end
            RRSA_ROTATE_RIGHT_CARRY_TO_WREG:
            begin
                r.wreg         = {f.carry_flag, m[7:1]};
                r.flags.carry_flag = m[0];
            end
            RRSA_SUBTRACT_BORROW_TO_WREG,
            RRSA_SUBTRACT_BORROW_TO_MEM:
            begin
                if (op == RRSA_SUBTRACT_BORROW_TO_WREG)
                begin
                    r.wreg = res;
                end
                else
                begin
                    r.mem_data = res;
                    r.mem_we   = 1'b1;
                end
                // borrow out of bit 7 means a negative difference
                r.flags.carry_flag      = ~diff[8];
                r.flags.half_carry_flag = ~low[4];
                r.flags.zero_flag       = (res == 8'h00);
                r.flags.sign_error_flag = (a[7] ^ m[7]) & (a[7] ^ res[7]);
                r.flags.signed_borrow_flag =
                    r.flags.sign_error_flag ^ res[7];
                // chains zero across multi-byte subtracts
                r.flags.carry_with_zero_flag =
                    (res == 8'h00) & f.carry_with_zero_flag;
            end
            default:
            begin
                r.mem_we = 1'b0;
            end
        endcase
        return r;
    endfunction : alu_exec

    logic [7:0]   wreg_r;
    rrsa_flags_t  flags_r;
    logic [7:0]   operand_r;
    logic [2:0]   ctrl_op_r;
    logic         mem_wr_en_r;
    logic [7:0]   mem_wr_data_r;
    logic [7:0]   result_r;
    logic         aw_held_r;
    logic [7:0]   awaddr_r;
    logic         w_held_r;
    logic [31:0]  wdata_r;
    logic [3:0]   wstrb_r;
    logic         bvalid_r;
    logic [1:0]   bresp_r;
    logic         rvalid_r;
    logic [31:0]  rdata_r;
    logic [1:0]   rresp_r;

    // write decode: a write completes once address and data are both held
    wire          wr_do      = aw_held_r & w_held_r & ~bvalid_r;
    wire          wr_b0      = wr_do & wstrb_r[0];
    wire          wr_ctrl    = wr_b0 & (awaddr_r == `RRSA_OFF_CTRL);
    wire          wr_operand = wr_b0 & (awaddr_r == `RRSA_OFF_OPERAND);
    wire          wr_wreg    = wr_b0 & (awaddr_r == `RRSA_OFF_WREG);
    wire          wr_flags   = wr_b0 & (awaddr_r == `RRSA_OFF_FLAGS);
    wire          wr_mapped  = (awaddr_r == `RRSA_OFF_CTRL)
                             | (awaddr_r == `RRSA_OFF_OPERAND)
                             | (awaddr_r == `RRSA_OFF_WREG)
                             | (awaddr_r == `RRSA_OFF_FLAGS)
                             | (awaddr_r == `RRSA_OFF_RESULT);
    wire          sw_go      = wr_ctrl & wdata_r[`RRSA_CTRL_GO_BIT];

    // decoder port wins; a software go in the same cycle is dropped
    wire          run        = exec_valid | sw_go;
    wire rrsa_op_t run_op    = exec_valid ? exec_op
                                          : rrsa_op_t'(wdata_r[2:0]);
    wire [7:0]    run_mem    = exec_valid ? exec_mem_data : operand_r;
    wire rrsa_result_t run_res = alu_exec(run_op, wreg_r, run_mem, flags_r);

    // read decode
    wire          ar_hs      = s_axi_arvalid & ~rvalid_r;
    wire          rd_mapped  = (s_axi_araddr == `RRSA_OFF_CTRL)
                             | (s_axi_araddr == `RRSA_OFF_OPERAND)
                             | (s_axi_araddr == `RRSA_OFF_WREG)
                             | (s_axi_araddr == `RRSA_OFF_FLAGS)
                             | (s_axi_araddr == `RRSA_OFF_RESULT);
    wire [31:0]   rd_word    =
        (s_axi_araddr == `RRSA_OFF_CTRL)    ? {29'h0, ctrl_op_r} :
        (s_axi_araddr == `RRSA_OFF_OPERAND) ? {24'h0, operand_r} :
        (s_axi_araddr == `RRSA_OFF_WREG)    ? {24'h0, wreg_r} :
        (s_axi_araddr == `RRSA_OFF_FLAGS)   ? {26'h0, flags_r} :
        (s_axi_araddr == `RRSA_OFF_RESULT)  ? {24'h0, result_r} :
                                              32'h0000_0000;

    wire [7:0]    wreg_nxt   = run ? run_res.wreg
                             : wr_wreg ? wdata_r[7:0] : wreg_r;
    wire rrsa_flags_t flags_nxt = run ? run_res.flags
                             : wr_flags ? rrsa_flags_t'(wdata_r[5:0])
                             : flags_r;

    // architectural state
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wreg_r        <= `RRSA_RST_WREG;
            flags_r       <= `RRSA_RST_FLAGS;
            operand_r     <= `RRSA_RST_BYTE;
            ctrl_op_r     <= 3'h0;
            mem_wr_en_r   <= 1'b0;
            mem_wr_data_r <= `RRSA_RST_BYTE;
            result_r      <= `RRSA_RST_BYTE;
        end
        else
        begin
            wreg_r      <= wreg_nxt;
            flags_r     <= flags_nxt;
            mem_wr_en_r <= run & run_res.mem_we & exec_valid;
            if (run && run_res.mem_we)
            begin
                mem_wr_data_r <= run_res.mem_data;
                result_r      <= run_res.mem_data;
            end
            if (run)
            begin
                ctrl_op_r <= run_op;
            end
            if (wr_operand)
            begin
                operand_r <= wdata_r[7:0];
            end
        end
    end

    // write channels: address and data are taken independently
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_held_r <= 1'b0;
            awaddr_r  <= 8'h00;
            w_held_r  <= 1'b0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RRSA_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_do)
            begin
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_mapped ? `RRSA_RESP_OKAY : `RRSA_RESP_SLVERR;
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
            end
            else if (bvalid_r && s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel: one read in flight, data registered
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `RRSA_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_mapped ? `RRSA_RESP_OKAY : `RRSA_RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // outputs
    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready  = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign mem_wr_en     = mem_wr_en_r;
    assign mem_wr_data   = mem_wr_data_r;
    assign wreg_out      = wreg_r;
    assign flags_out     = flags_r;

endmodule : rrsa_alu

// *** verif/rrsa_alu_chk.sv ***
// decoder-side assertions for the rotate/subtract alu
`timescale 1ns/100ps
module rrsa_alu_chk
(
    input wire logic                  core_clk,      // clock
    input wire logic                  nrst,          // reset, low
    input wire logic                  exec_valid,    // op issued
    input wire rrsa_pkg::rrsa_op_t    exec_op,       // op code
    input wire logic [7:0]            exec_mem_data, // operand byte
    input wire logic                  mem_wr_en,     // write pulse
    input wire logic [7:0]            mem_wr_data,   // write byte
    input wire logic [7:0]            wreg_out,      // working reg
    input wire rrsa_pkg::rrsa_flags_t flags_out      // flags
);
    import rrsa_pkg::*;
    logic [7:0]  a_r;
    logic [7:0]  m_r;
    rrsa_flags_t f_r;
    logic [8:0]  dif;
    logic        sub;
    // operands as the op saw them, held for the cycle after
    always_ff @(posedge core_clk)
    begin
        a_r <= wreg_out;
        m_r <= exec_mem_data;
        f_r <= flags_out;
    end
    // ninth bit is the borrow out of the whole byte
    assign dif = {1'b0, a_r} - {1'b0, m_r} - {8'h00, ~f_r.carry_flag};
    assign sub = exec_valid && exec_op[2] && !exec_op[1];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_ROT_MEM: assert property (
        exec_valid && exec_op == RRSA_ROTATE_RIGHT_MEM |=> mem_wr_en &&
        mem_wr_data == {m_r[0], m_r[7:1]} && flags_out == f_r)
        else $error("rotate to memory wrong");
    AST_ROT_WREG: assert property (
        exec_valid && exec_op == RRSA_ROTATE_RIGHT_TO_WREG |=> !mem_wr_en &&
        wreg_out == {m_r[0], m_r[7:1]} && flags_out == f_r)
        else $error("rotate to wreg wrong");
    AST_RC_MEM: assert property (
        exec_valid && exec_op == RRSA_ROTATE_RIGHT_CARRY_MEM |=> mem_wr_en &&
        mem_wr_data == {f_r.carry_flag, m_r[7:1]} &&
        flags_out == {f_r[5:1], m_r[0]})
        else $error("carry rotate to memory wrong");
    AST_RC_WREG: assert property (
        exec_valid && exec_op == RRSA_ROTATE_RIGHT_CARRY_TO_WREG |=>
        !mem_wr_en && wreg_out == {f_r.carry_flag, m_r[7:1]} &&
        flags_out == {f_r[5:1], m_r[0]})
        else $error("carry rotate to wreg wrong");
    AST_SB_WREG: assert property (
        exec_valid && exec_op == RRSA_SUBTRACT_BORROW_TO_WREG |=>
        !mem_wr_en && wreg_out == dif[7:0])
        else $error("subtract to wreg wrong");
    AST_SB_MEM: assert property (
        exec_valid && exec_op == RRSA_SUBTRACT_BORROW_TO_MEM |=>
        mem_wr_en && mem_wr_data == dif[7:0] && wreg_out == a_r)
        else $error("subtract to memory wrong");
    AST_SB_CARRY: assert property (
        sub |=> flags_out.carry_flag == !dif[8])
        else $error("subtract carry wrong");
    AST_SB_ZERO: assert property (
        sub |=> flags_out.zero_flag == (dif[7:0] == 8'h00) &&
        flags_out.carry_with_zero_flag ==
        (dif[7:0] == 8'h00 && f_r.carry_with_zero_flag))
        else $error("subtract zero flags wrong");
    AST_WR_CAUSE: assert property (
        mem_wr_en |-> $past(exec_valid) && $past(exec_op) inside
        {RRSA_ROTATE_RIGHT_MEM, RRSA_ROTATE_RIGHT_CARRY_MEM,
        RRSA_SUBTRACT_BORROW_TO_MEM})
        else $error("memory write without cause");
endmodule : rrsa_alu_chk

// *** verif/rrsa_dec_mem.sv ***
// decoder and four-byte data memory facing the alu
`timescale 1ns/100ps
module rrsa_dec_mem
(
    input  wire logic         core_clk,      // clock
    input  wire logic         nrst,          // reset, low
    input  wire logic         req,           // issue one op
    input  wire rrsa_pkg::rrsa_op_t req_op,  // op to issue
    input  wire logic [1:0]   req_adr,       // byte address
    output logic              exec_valid,    // op pulse
    output rrsa_pkg::rrsa_op_t exec_op,      // op code
    output logic [7:0]        exec_mem_data, // addressed byte
    input  wire logic         mem_wr_en,     // write pulse
    input  wire logic [7:0]   mem_wr_data    // write byte
);
    import rrsa_pkg::*;
    logic [7:0] mem [4];
    logic [1:0] adr_r;
    // idle byte lane flips each cycle so stale data never looks valid
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            exec_valid <= 1'b0;
            exec_op <= RRSA_NOP6;
            exec_mem_data <= 8'h5a;
            adr_r <= 2'h0;
            mem <= '{8'h00, 8'h01, 8'h80, 8'hff};
        end
        else
        begin
            exec_valid <= req;
            exec_op <= req_op;
            exec_mem_data <= req ? mem[req_adr] : ~exec_mem_data;
            if (req)
                adr_r <= req_adr;
            if (mem_wr_en)
                mem[adr_r] <= mem_wr_data;
        end
    end
endmodule : rrsa_dec_mem

// *** verif/tb_rrsa_alu.sv ***
// random and corner-case bench for the rotate/subtract alu
`timescale 1ns/100ps
`include "rrsa_defs.svh"
module tb_rrsa_alu;
    import rrsa_pkg::*;
    logic        core_clk = 1'b0, nrst = 1'b0, req = 1'b0;
    logic [1:0]  req_adr = 2'h0, rs, s_axi_bresp, s_axi_rresp;
    rrsa_op_t    req_op = RRSA_NOP6, exec_op;
    logic        exec_valid, mem_wr_en, s_axi_bvalid, s_axi_rvalid;
    logic [7:0]  exec_mem_data, mem_wr_data, wreg_out, w, m;
    rrsa_flags_t flags_out, exp_fl = '0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_arready;
    logic [7:0]  exp_wreg = 8'h00, exp_mem [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
    rrsa_result_t e;
    integer      seed = 76408, errors = 0, checked = 0, i;
    rrsa_alu dut (.core_clk, .nrst, .exec_valid, .exec_op, .exec_mem_data,
        .mem_wr_en, .mem_wr_data, .wreg_out, .flags_out, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rrsa_dec_mem u_dec (.core_clk, .nrst, .req, .req_op, .req_adr,
        .exec_valid, .exec_op, .exec_mem_data, .mem_wr_en, .mem_wr_data);
    always #2.5 core_clk = ~core_clk;
    // expected outcome; op bit 1 picks carry, bit 0 picks destination
    function automatic rrsa_result_t calc(rrsa_op_t op, logic [7:0] a,
        logic [7:0] b, rrsa_flags_t f);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] t;
        rrsa_result_t r;
        d = {1'b0, a} - {1'b0, b} - {8'h00, ~f.carry_flag};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~f.carry_flag};
        t = op[2] ? d[7:0] : {op[1] ? f.carry_flag : b[0], b[7:1]};
        r = '{wreg: a, mem_data: t, mem_we: op inside {3'h0, 3'h2, 3'h5},
            flags: f};
        if (op < 3'h6 && (op[2] ^ op[0]))
            r.wreg = t;
        if (op == 3'h2 || op == 3'h3)
            r.flags.carry_flag = b[0];
        if (op[2] && !op[1])
            r.flags = '{t == 8'h00 && f.carry_with_zero_flag,
                (a[7] ^ b[7]) & (t[7] ^ a[7]) ^ t[7],
                (a[7] ^ b[7]) & (t[7] ^ a[7]), t == 8'h00, ~h[4], ~d[8]};
        return r;
    endfunction : calc
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checked = checked + 1;
        if (got !== ex)
        begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task print_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // one decoder op, then compare and follow the memory write-back
    task automatic run_op(input rrsa_op_t op, input logic [1:0] ad);
        e = calc(op, exp_wreg, exp_mem[ad], exp_fl);
        req <= 1'b1;
        req_op <= op;
        req_adr <= ad;
        @(posedge core_clk);
        req <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("wreg", 32'(e.wreg), 32'(wreg_out));
        chk("flags", 32'(e.flags), 32'(flags_out));
        chk("mem_we", 32'(e.mem_we), 32'(mem_wr_en));
        if (e.mem_we)
            chk("mem", 32'(e.mem_data), 32'(mem_wr_data));
        @(posedge core_clk);
        exp_wreg = e.wreg;
        exp_fl = e.flags;
        if (e.mem_we)
            exp_mem[ad] = e.mem_data;
    endtask : run_op
    // both channels offered together; either may be taken first
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rs = s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask : axi_rd
    // a hang counts as a mismatch
    initial
    begin
        #100000;
        errors = errors + 1;
        print_verdict;
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        chk("rst_wreg", 32'(`RRSA_RST_WREG), 32'(wreg_out));
        chk("rst_flags", 32'(`RRSA_RST_FLAGS), 32'(flags_out));
        nrst <= 1'b1;
        for (i = 0; i < 8; i++)
            run_op(rrsa_op_t'(i), 2'(i));
        w = 8'($random(seed));
        m = 8'($random(seed));
        axi_wr(`RRSA_OFF_WREG, {24'h0, w});
        chk("bresp", 32'(`RRSA_RESP_OKAY), 32'(rs));
        axi_wr(`RRSA_OFF_FLAGS, 32'h20);
        axi_rd(`RRSA_OFF_WREG);
        chk("rd_wreg", {24'h0, w}, rd);
        axi_wr(`RRSA_OFF_OPERAND, {24'h0, m});
        axi_wr(`RRSA_OFF_CTRL, 32'h0c);
        e = calc(RRSA_SUBTRACT_BORROW_TO_WREG, w, m, 6'h20);
        axi_rd(`RRSA_OFF_WREG);
        chk("sw_wreg", 32'(e.wreg), rd);
        axi_rd(`RRSA_OFF_FLAGS);
        chk("sw_flags", 32'(e.flags), rd);
        exp_wreg = e.wreg;
        exp_fl = e.flags;
        // software-started memory op lands in the result register only
        axi_wr(`RRSA_OFF_CTRL, 32'h0d);
        e = calc(RRSA_SUBTRACT_BORROW_TO_MEM, exp_wreg, m, exp_fl);
        axi_rd(`RRSA_OFF_RESULT);
        chk("sw_result", 32'(e.mem_data), rd);
        chk("rresp", 32'(`RRSA_RESP_OKAY), 32'(rs));
        axi_rd(`RRSA_OFF_WREG);
        chk("sw_wreg_kept", 32'(exp_wreg), rd);
        axi_rd(`RRSA_OFF_FLAGS);
        chk("sw_flags_mem", 32'(e.flags), rd);
        axi_rd(`RRSA_OFF_CTRL);
        chk("ctrl_op", 32'h0000_0005, rd);
        exp_fl = e.flags;
        axi_wr(8'h40, 32'h1);
        chk("bad_wr", 32'(`RRSA_RESP_SLVERR), 32'(rs));
        axi_rd(8'h40);
        chk("bad_rd", 32'(`RRSA_RESP_SLVERR), 32'(rs));
        for (i = 0; i < 80; i++)
            run_op(rrsa_op_t'(3'($random(seed))), 2'($random(seed)));
        print_verdict;
    end
endmodule : tb_rrsa_alu
bind rrsa_alu rrsa_alu_chk u_chk (.core_clk, .nrst, .exec_valid, .exec_op,
    .exec_mem_data, .mem_wr_en, .mem_wr_data, .wreg_out, .flags_out);
